// ### nat_access_timing.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "nat_regs.svh"

// How it works
// (R1) One delay setting times reads and writes; select low two cycles plus setting for 0-4, the table total above.
// (R2) The setting sits at bits 4:2; 0-3 add waits, 4-7 extended modes.
// (R3) Codes 0-3 give 2, 3, 4, 5 cycles; code 1 after reset.
// (R4) Codes 4-7 give 6, 9, 17 and 32 cycles per access.
// (R5) Writes have setup, strobe, hold; settings 0-1 use half-cycle setup and hold.
// (R6) Write setup/active/hold follow the table for settings 2 to 7.
// (R7) Reads have setup then strobe, no hold; settings 0-3 use one setup cycle.
// (R8) Read setup/active follow the table for settings 4 to 7.
// (R9) The timing configuration register is write-only, eleven bits, bus clocked.
// (R10) With flash enabled the secondary ROM select is the flash select.
// (R11) Data is eight bits wide and the pins are shared with other devices.
// (R12) Every byte is its own access; strobe only in the active phase.
module nat_access_timing #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic acc_valid_i,
    input wire nat_pkg::nat_req_t acc_req_i,
    output logic acc_ready_o,
    output logic acc_done_o,
    output logic [7:0] acc_rdata_o,
    output logic secondary_rom_select_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o,
    output logic [7:0] flash_data_o,
    output logic flash_data_oe_o,
    input wire logic [7:0] flash_data_i,
    input wire logic flash_ready_busy_n_i
);

    // ****************************************************************
    // Phase lookup.
    // ****************************************************************

    // Maps a delay setting to its total, write strobe and read setup counts.
    function automatic nat_pkg::nat_phase_t phase_of(input logic [2:0] s);
        nat_pkg::nat_phase_t p;
        case (s)
            3'h0: p = '{`NAT_TOT_0, `NAT_WACT_0, `NAT_RSET_0};
            3'h1: p = '{`NAT_TOT_1, `NAT_WACT_1, `NAT_RSET_1};
            3'h2: p = '{`NAT_TOT_2, `NAT_WACT_2, `NAT_RSET_2};
            3'h3: p = '{`NAT_TOT_3, `NAT_WACT_3, `NAT_RSET_3};
            3'h4: p = '{`NAT_TOT_4, `NAT_WACT_4, `NAT_RSET_4};
            3'h5: p = '{`NAT_TOT_5, `NAT_WACT_5, `NAT_RSET_5};
            3'h6: p = '{`NAT_TOT_6, `NAT_WACT_6, `NAT_RSET_6};
            3'h7: p = '{`NAT_TOT_7, `NAT_WACT_7, `NAT_RSET_7};
            default: p = '{`NAT_TOT_1, `NAT_WACT_1, `NAT_RSET_1};
        endcase
        return p;
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [`NAT_CFG_W-1:0] cfg_reg;
    logic [DATA_W-1:0] rdata_reg;
    nat_pkg::nat_state_t state_reg;
    nat_pkg::nat_state_t state_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [2:0] lat_set_reg;
    logic lat_wr_reg;
    logic sel_n_reg;
    logic sel_n_next;
    logic we_p_n_reg;
    logic we_p_n_next;
    logic we_h_n_reg;
    logic we_h_n_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic [7:0] dout_reg;
    logic doe_reg;
    logic doe_next;
    logic done_reg;
    logic [7:0] rdat_reg;
    logic ready_reg;
    logic [2:0] rb_sync_reg;
    logic rb_reg;

    // ****************************************************************
    // Register decode.
    // ****************************************************************

    // The configuration register answers writes only; reads of it return zero.
    wire cfg_hit = reg_wr_i && (reg_addr_i == ADDR_W'(`NAT_CFG_ADDR)); // R9
    wire stat_hit = reg_rd_i && (reg_addr_i == ADDR_W'(`NAT_STAT_ADDR));
    wire [2:0] cfg_set = cfg_reg[`NAT_SET_MSB:`NAT_SET_LSB]; // R2
    wire cfg_en = cfg_reg[`NAT_EN_BIT]; // R10
    wire busy = (state_reg == nat_pkg::NAT_BUSY);
    wire [DATA_W-1:0] status_word = DATA_W'({lat_set_reg, cfg_en, rb_reg, busy});
    wire [DATA_W-1:0] rdata_next = stat_hit ? status_word : '0;

    // ****************************************************************
    // Access sequencing.
    // ****************************************************************

    // The setting is latched at the start, so a config write mid-access cannot tear timing.
    wire nat_pkg::nat_phase_t cur = phase_of(lat_set_reg);
    // Enable is checked again here, as ready lags a disabling write by one cycle.
    wire start = !busy && ready_reg && cfg_en && acc_valid_i; // R10
    wire last = busy && (cnt_reg == cur.total - `NAT_CNT_ONE); // R1
    wire [2:0] nxt_set = start ? cfg_set : lat_set_reg; // R1
    wire nxt_wr = start ? acc_req_i.write : lat_wr_reg;
    wire nat_pkg::nat_phase_t nxt = phase_of(nxt_set);
    wire nxt_half = nxt_set <= `NAT_HALF_LAST;
    wire in_next = start || (busy && !last); // R12
    wire half_mode = lat_wr_reg && (lat_set_reg <= `NAT_HALF_LAST); // R5

    // Counter and state; the counter indexes the bus cycle inside the access.
    assign state_next = in_next ? nat_pkg::NAT_BUSY : nat_pkg::NAT_IDLE;
    assign cnt_next = start ? 6'h00 : (busy ? cnt_reg + `NAT_CNT_ONE : cnt_reg);

    // Select covers the whole access: total = 2 + setting or the extended figure.
    assign sel_n_next = !in_next; // R1 R3 R4 R10

    // Whole-cycle write strobe: one setup cycle, then the active run, the rest is hold.
    assign we_p_n_next = !(in_next && nxt_wr && !nxt_half && (cnt_next >= `NAT_WR_SETUP)
                           && (cnt_next < `NAT_WR_SETUP + nxt.wr_active)); // R6 R12

    // Half-cycle write strobe, sampled on the falling edge: low from 0.5 to active + 0.5.
    assign we_h_n_next = !(busy && half_mode && (cnt_reg < cur.wr_active)); // R5

    // Read strobe runs from the end of setup to the end of the select, so no hold.
    assign oe_n_next = !(in_next && !nxt_wr && (cnt_next >= nxt.rd_setup)
                         && (cnt_next < nxt.total)); // R7 R8 R12

    // The data pins are driven only while our own write owns the shared bus.
    assign doe_next = in_next && nxt_wr; // R11

    // Only the strobe with half-cycle edges needs the falling-edge flop; the select is static per access.
    assign flash_we_n_o = half_mode ? we_h_n_reg : we_p_n_reg; // R5

    // ****************************************************************
    // Flip-flops.
    // ****************************************************************

    // Configuration register and read port.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_reg <= `NAT_CFG_RESET; // R3
            rdata_reg <= '0;
        end else begin
            if (cfg_hit) begin
                cfg_reg <= reg_wdata_i[`NAT_CFG_W-1:0]; // R9
            end
            rdata_reg <= rdata_next;
        end
    end

    // Sequencer core.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= nat_pkg::NAT_IDLE;
            cnt_reg <= 6'h00;
            lat_set_reg <= `NAT_SET_RESET;
            lat_wr_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            lat_set_reg <= nxt_set;
            lat_wr_reg <= nxt_wr;
            ready_reg <= cfg_en && !in_next; // R10
        end
    end

    // Pin-side outputs, all idle-high or idle-off.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_n_reg <= 1'b1;
            we_p_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            doe_reg <= 1'b0;
            dout_reg <= 8'h00;
        end else begin
            sel_n_reg <= sel_n_next;
            we_p_n_reg <= we_p_n_next;
            oe_n_reg <= oe_n_next;
            doe_reg <= doe_next;
            if (start) begin
                dout_reg <= acc_req_i.data; // R11
            end
        end
    end

    // Falling-edge half of the write strobe.
    always_ff @(negedge clk_i) begin
        if (reset_i) begin
            we_h_n_reg <= 1'b1;
        end else begin
            we_h_n_reg <= we_h_n_next; // R5
        end
    end

    // Completion and read capture; the byte is sampled on the edge that ends the strobe.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            done_reg <= last;
            if (last && !lat_wr_reg) begin
                rdat_reg <= flash_data_i; // R7
            end
        end
    end

    // Ready/busy is asynchronous; a level is taken once stages two and three agree.
    // The line idles high on its pull-up, so reset starts there and shows no false busy.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rb_sync_reg <= `NAT_RB_IDLE;
            rb_reg <= 1'b1;
        end else begin
            rb_sync_reg <= {rb_sync_reg[1:0], flash_ready_busy_n_i};
            if (rb_sync_reg[1] == rb_sync_reg[2]) begin
                rb_reg <= rb_sync_reg[2];
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign acc_ready_o = ready_reg;
    assign acc_done_o = done_reg;
    assign acc_rdata_o = rdat_reg;
    assign secondary_rom_select_n_o = sel_n_reg;
    assign flash_oe_n_o = oe_n_reg;
    assign flash_data_o = dout_reg;
    assign flash_data_oe_o = doe_reg;

    // ****************************************************************
    // Checks.
    // ****************************************************************

    // Cycle counts of low select, write strobe and read strobe, seen at rising edges.
    logic [5:0] sel_len;
    logic [5:0] we_len;
    logic [5:0] oe_len;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_len <= 6'h00;
            we_len <= 6'h00;
            oe_len <= 6'h00;
        end else begin
            sel_len <= sel_n_reg ? 6'h00 : sel_len + `NAT_CNT_ONE;
            we_len <= flash_we_n_o ? 6'h00 : we_len + `NAT_CNT_ONE;
            oe_len <= oe_n_reg ? 6'h00 : oe_len + `NAT_CNT_ONE;
        end
    end

    default clocking nat_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_select_length: assert property ($rose(secondary_rom_select_n_o) |-> sel_len == cur.total) // R1
        else $error("select low time differs from the setting total");
    a_reset_setting: assert property ($fell(reset_i) |-> cfg_set == 3'h1 ##1 (cfg_set == 3'h1 || $past(cfg_hit))) // R3
        else $error("delay setting is not one after reset");
    a_setting_field: assert property (cfg_hit |=> cfg_set == $past(reg_wdata_i[`NAT_SET_MSB:`NAT_SET_LSB])) // R2
        else $error("delay field not taken from bits four to two");
    a_write_strobe: assert property ($rose(flash_we_n_o) && !$past(half_mode, 2) |-> we_len == cur.wr_active) // R6
        else $error("write strobe length wrong");
    a_half_strobe: assert property ($rose(flash_we_n_o) && half_mode |-> we_len == cur.wr_active ##1 sel_n_reg) // R5
        else $error("half-cycle write strobe length or hold wrong");
    a_read_setup: assert property ($fell(flash_oe_n_o) |-> sel_len == cur.rd_setup) // R8
        else $error("read setup length wrong");
    a_read_no_hold: assert property ($rose(secondary_rom_select_n_o) && !lat_wr_reg |-> $rose(flash_oe_n_o)
                                     && oe_len == cur.total - cur.rd_setup) // R7
        else $error("read strobe not ending with the select");
    a_strobe_inside: assert property (!flash_oe_n_o || !we_p_n_reg |-> !secondary_rom_select_n_o) // R12
        else $error("strobe outside the select");
    a_disabled_quiet: assert property (!cfg_en && !busy |=> secondary_rom_select_n_o [*2]) // R10
        else $error("select asserted while flash disabled");
    a_data_drive: assert property (flash_data_oe_o |-> !secondary_rom_select_n_o && lat_wr_reg) // R11
        else $error("data pins driven outside a write");

    c_write_half: cover property ($rose(secondary_rom_select_n_o) && half_mode);
    c_read_long: cover property ($rose(secondary_rom_select_n_o) && !lat_wr_reg && lat_set_reg == 3'h7);
    c_back_to_back: cover property (acc_done_o && $fell(secondary_rom_select_n_o));
    c_cfg_write: cover property (cfg_hit ##1 start);

endmodule

// ### nat_regs.svh
`ifndef NAT_REGS_SVH
`define NAT_REGS_SVH

// ****************************************************************
// Register map of the access timing block.
// ****************************************************************
`define NAT_CFG_ADDR 32'h6400031C
`define NAT_STAT_ADDR 32'h64000320
`define NAT_CFG_W 11
`define NAT_CFG_RESET 11'h004
`define NAT_EN_BIT 0
`define NAT_SET_LSB 2
`define NAT_SET_MSB 4
`define NAT_ST_BUSY 0
`define NAT_ST_RDY 1
`define NAT_ST_EN 2
`define NAT_ST_SET_LSB 3
`define NAT_ST_SET_MSB 5
`define NAT_SET_RESET 3'h1
`define NAT_RB_IDLE 3'h7

// ****************************************************************
// Phase counts in bus clock cycles, one set per delay setting.
// ****************************************************************
`define NAT_CNT_ONE 6'h01
`define NAT_WR_SETUP 6'h01
`define NAT_HALF_LAST 3'h1
`define NAT_TOT_0 6'h02
`define NAT_TOT_1 6'h03
`define NAT_TOT_2 6'h04
`define NAT_TOT_3 6'h05
`define NAT_TOT_4 6'h06
`define NAT_TOT_5 6'h09
`define NAT_TOT_6 6'h11
`define NAT_TOT_7 6'h20
`define NAT_WACT_0 6'h01
`define NAT_WACT_1 6'h02
`define NAT_WACT_2 6'h02
`define NAT_WACT_3 6'h03
`define NAT_WACT_4 6'h03
`define NAT_WACT_5 6'h05
`define NAT_WACT_6 6'h08
`define NAT_WACT_7 6'h10
`define NAT_RSET_0 6'h01
`define NAT_RSET_1 6'h01
`define NAT_RSET_2 6'h01
`define NAT_RSET_3 6'h01
`define NAT_RSET_4 6'h02
`define NAT_RSET_5 6'h04
`define NAT_RSET_6 6'h09
`define NAT_RSET_7 6'h11

`endif

// ### nat_pkg.sv
package nat_pkg;

    // Phase counts of one delay setting; write hold and read active follow from the total.
    typedef struct packed {
        logic [5:0] total;
        logic [5:0] wr_active;
        logic [5:0] rd_setup;
    } nat_phase_t;

    // One byte access requested by the controller.
    typedef struct packed {
        logic write;
        logic [7:0] data;
    } nat_req_t;

    typedef enum logic {
        NAT_IDLE,
        NAT_BUSY
    } nat_state_t;

endpackage

// ### nat_flash_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Byte-wide flash device seen from its pins.
// ****************************************************************
module nat_flash_model (
    input wire logic clk_i,
    input wire logic select_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    output logic [7:0] data_o,
    output logic ready_busy_n_o
);
    logic [7:0] last_wr = 8'h00;
    logic [2:0] busy_cnt = 3'h0;
    logic [7:0] bus_reg = 8'h00;
    int wr_events = 0;
    int wr_taken = 0;

    // A byte is captured when the write strobe ends inside a selected cycle.
    always @(posedge we_n_i) begin
        if (!select_n_i && data_oe_i) begin
            last_wr = data_i;
            wr_events++;
        end
    end

    // The pins carry no pull, so a released bus toggles to expose stale sampling.
    always @(clk_i) begin
        if (!select_n_i && !oe_n_i) begin
            bus_reg <= last_wr ^ 8'h5A;
        end else begin
            bus_reg <= ~bus_reg;
        end
    end

    // Short busy period after each programmed byte; one process owns the counter.
    always @(posedge clk_i) begin
        if (wr_taken != wr_events) begin
            wr_taken <= wr_events;
            busy_cnt <= 3'h3;
        end else if (busy_cnt != 3'h0) begin
            busy_cnt <= busy_cnt - 3'h1;
        end
    end

    assign data_o = bus_reg;
    assign ready_busy_n_o = (busy_cnt == 3'h0);
endmodule

// ### nand_access_timing_tb.sv
`timescale 1ns/100ps
`include "nat_regs.svh"

// ****************************************************************
// Self-checking bench for the access timing block.
// ****************************************************************
module nand_access_timing_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] reg_addr_i = 32'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic acc_valid_i = 1'b0;
    nat_pkg::nat_req_t acc_req_i = '0;
    logic acc_ready_o, acc_done_o, sel_n, we_n, oe_n, d_oe, rb_n;
    logic [7:0] acc_rdata_o, d_out, d_model, d_wire;
    logic [31:0] rd;
    int bad_count = 0;
    int n_checks = 0;
    int tot[8] = '{2, 3, 4, 5, 6, 9, 17, 32};
    int wact[8] = '{1, 2, 2, 3, 3, 5, 8, 16};
    int rset[8] = '{1, 1, 1, 1, 2, 4, 9, 17};
    logic [7:0] last_byte = 8'h00;

    always #12.5 clk_i = ~clk_i;

    // The data wire follows the block while it enables its driver, and the flash model otherwise.
    assign d_wire = d_oe ? d_out : d_model;

    nat_access_timing i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .acc_valid_i(acc_valid_i), .acc_req_i(acc_req_i), .acc_ready_o(acc_ready_o),
        .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o), .secondary_rom_select_n_o(sel_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_data_o(d_out), .flash_data_oe_o(d_oe),
        .flash_data_i(d_wire), .flash_ready_busy_n_i(rb_n));

    nat_flash_model i_flash (.clk_i(clk_i), .select_n_i(sel_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .data_i(d_out), .data_oe_i(d_oe), .data_o(d_model), .ready_busy_n_o(rb_n));

    // Expected status word; busy is clear whenever the bench reads it.
    function automatic logic [31:0] stat(input logic en, input logic [2:0] s);
        stat = {26'h0, s, en, 1'b1, 1'b0};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // One byte access; phases are counted in half cycles by sampling after every clock edge.
    task automatic do_acc(input logic wr, input logic [7:0] d, input logic [2:0] s);
        int i, sel, stb, setup, other;
        logic seen_stb;
        sel = 0;
        stb = 0;
        setup = 0;
        other = 0;
        seen_stb = 1'b0;
        for (i = 0; i < 60 && acc_ready_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 60) begin
            bad_count++;
            final_report();
        end
        @(posedge clk_i);
        acc_valid_i <= 1'b1;
        acc_req_i <= '{write: wr, data: d};
        @(posedge clk_i);
        acc_valid_i <= 1'b0;
        #1;
        for (i = 0; i < 100 && sel_n === 1'b0; i++) begin
            sel++;
            if ((wr ? we_n : oe_n) === 1'b0) begin
                stb++;
                seen_stb = 1'b1;
            end else if (!seen_stb) begin
                setup++;
            end
            if ((wr ? oe_n : we_n) !== 1'b1) other++;
            @(clk_i);
            #1;
        end
        if (i == 100) begin
            bad_count++;
            final_report();
        end
        check("select halves", sel, 2 * tot[s]);
        check("other strobe", other, 0);
        check("done pulse", acc_done_o, 1'b1);
        if (wr) begin
            check("write setup", setup, (s < 2) ? 1 : 2);
            check("write active", stb, 2 * wact[s]);
            check("byte written", i_flash.last_wr, d);
            last_byte = d;
        end else begin
            check("read setup", setup, 2 * rset[s]);
            check("read active", stb, 2 * (tot[s] - rset[s]));
            check("byte read", acc_rdata_o, last_byte ^ 8'h5A);
        end
        @(posedge clk_i);
        #1 check("done width", acc_done_o, 1'b0);
    endtask

    initial begin
        int k;
        logic [2:0] s;
        void'($urandom(32'h3895));
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_read(`NAT_STAT_ADDR, rd);
        check("reset status", rd, stat(1'b0, 3'h1));
        check("ready before enable", acc_ready_o, 1'b0);
        reg_read(`NAT_CFG_ADDR, rd);
        check("config readback", rd, 32'h0);
        reg_write(32'h64000400, 32'h0000001D);
        reg_read(32'h64000400, rd);
        check("unmapped read", rd, 32'h0);
        reg_read(`NAT_STAT_ADDR, rd);
        check("unmapped write", rd, stat(1'b0, 3'h1));
        $display("test registers done");
        // Every setting, with random stored bits above the field, times a write then a read.
        for (k = 0; k < 8; k++) begin
            reg_write(`NAT_CFG_ADDR, {21'h0, 6'($urandom), 3'(k), 1'b0, 1'b1});
            do_acc(1'b1, 8'($urandom), 3'(k));
            do_acc(1'b0, 8'h00, 3'(k));
            // Status shows the setting latched by the last access, so it is read afterwards.
            reg_read(`NAT_STAT_ADDR, rd);
            check("status setting", rd, stat(1'b1, 3'(k)));
        end
        $display("test settings done");
        for (k = 0; k < 6; k++) begin
            s = 3'($urandom);
            reg_write(`NAT_CFG_ADDR, {27'h0, s, 2'b01});
            do_acc(1'($urandom), 8'($urandom), s);
        end
        $display("test random done");
        // A second reset restores the default setting and blocks new accesses.
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        #1 check("ready after reset", acc_ready_o, 1'b0);
        reg_read(`NAT_STAT_ADDR, rd);
        check("status after reset", rd, stat(1'b0, 3'h1));
        $display("test second reset done");
        final_report();
    end
endmodule
